// ---- hw/ssr_err_mem.sv ----
// Word store of the error queue with registered read data
`timescale 1ns/1ns
`default_nettype none
module ssr_err_mem
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [ssr_pkg::QUEUE_AW-1:0] wr_addr,
  input wire logic signed [ssr_pkg::DATA_W-1:0] wr_data,
  input wire logic [ssr_pkg::QUEUE_AW-1:0] rd_addr,
  output logic signed [ssr_pkg::DATA_W-1:0] rd_data
);

  typedef struct packed {
    logic [QUEUE_DEPTH-1:0][DATA_W-1:0] words;
    logic [DATA_W-1:0] rd_word;
  } ssr_mem_state_t;

  ssr_mem_state_t mem_q;
  ssr_mem_state_t mem_d;

  // Read sees the old word when the same entry is written in that cycle
  always_comb begin
    mem_d = mem_q;
    mem_d.rd_word = mem_q.words[rd_addr];
    if (wr_en) begin
      mem_d.words[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    mem_q <= mem_d;
  end

  assign rd_data = mem_q.rd_word;

endmodule : ssr_err_mem
`default_nettype wire

// ---- hw/ssr_pkg.sv ----
// Constants, address map and helpers for the status reporting register bank
package ssr_pkg;

  localparam int DATA_W = 16;
  localparam int NUM_CH = 2;
  localparam int CH_W = 1;
  localparam int NUM_WIN = 2;
  localparam int SUB_PER_CH = 13;
  localparam int NUM_REGS = 2 + NUM_CH * SUB_PER_CH;
  localparam int IDX_W = 5;

  // Register address: {chan_named, chan, slot[3:0], part[2:0]}
  localparam int ADDR_W = 9;
  localparam int PART_LSB = 0;
  localparam int PART_W = 3;
  localparam int SLOT_LSB = 3;
  localparam int SLOT_W = 4;
  localparam int CHAN_BIT = 7;
  localparam int NAMED_BIT = 8;

  // Slot codes; per-channel sub-registers occupy slots 2 to 14
  localparam logic [SLOT_W-1:0] SLOT_OPER = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_QUES = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_ACP = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_EXT = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_EXT_EXTENDED_REG_A = 4'h4;
  localparam logic [SLOT_W-1:0] SLOT_FREQ = 4'h5;
  localparam logic [SLOT_W-1:0] SLOT_LIMIT_W0 = 4'h6;
  localparam logic [SLOT_W-1:0] SLOT_LIMIT_W1 = 4'h7;
  localparam logic [SLOT_W-1:0] SLOT_LIMIT_MARGIN_REG_W0 = 4'h8;
  localparam logic [SLOT_W-1:0] SLOT_LIMIT_MARGIN_REG_W1 = 4'h9;
  localparam logic [SLOT_W-1:0] SLOT_PHASE_NOISE_REG = 4'hA;
  localparam logic [SLOT_W-1:0] SLOT_POWER = 4'hB;
  localparam logic [SLOT_W-1:0] SLOT_DC_POWER_NOISE_REG = 4'hC;
  localparam logic [SLOT_W-1:0] SLOT_TEMP = 4'hD;
  localparam logic [SLOT_W-1:0] SLOT_TIME = 4'hE;
  localparam logic [SLOT_W-1:0] SLOT_CTRL = 4'hF;

  // Parts of a status register
  localparam logic [PART_W-1:0] PART_COND = 3'h0;
  localparam logic [PART_W-1:0] PART_EVENT = 3'h1;
  localparam logic [PART_W-1:0] PART_ENABLE = 3'h2;
  localparam logic [PART_W-1:0] PART_PTR = 3'h3;
  localparam logic [PART_W-1:0] PART_NTR = 3'h4;

  // Parts of the control slot
  localparam logic [PART_W-1:0] CTRL_QUEUE = 3'h0;
  localparam logic [PART_W-1:0] CTRL_PRESET = 3'h1;
  localparam logic [PART_W-1:0] CTRL_ACTIVE = 3'h2;
  localparam logic [PART_W-1:0] CTRL_IRQ_STAT = 3'h3;
  localparam logic [PART_W-1:0] CTRL_IRQ_EN = 3'h4;
  localparam logic [PART_W-1:0] CTRL_IRQ_CLR = 3'h5;

  localparam logic [IDX_W-1:0] IDX_OPER = 5'h00;
  localparam logic [IDX_W-1:0] IDX_QUES = 5'h01;
  localparam logic [IDX_W-1:0] IDX_SUB_BASE = 5'h02;
  localparam logic [IDX_W-1:0] IDX_PER_CH = 5'h0D;

  localparam logic [DATA_W-1:0] PTR_PRESET = 16'hFFFF;
  localparam logic [DATA_W-1:0] NTR_PRESET = 16'h0000;
  localparam logic [DATA_W-1:0] ENA_PRESET = 16'h0000;
  localparam logic signed [DATA_W-1:0] NO_ERROR = 16'sh0000;

  localparam int QUEUE_DEPTH = 16;
  localparam int QUEUE_AW = 4;
  localparam int QCNT_W = 5;
  localparam logic [QCNT_W-1:0] QCNT_ONE = 5'h01;
  localparam logic [QCNT_W-1:0] QCNT_FULL = 5'h10;
  localparam logic [QCNT_W-1:0] QCNT_EMPTY = 5'h00;

  localparam int IRQ_W = 3;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_OPER = 1;
  localparam int IRQ_QUES = 2;

  // Flat register index from channel and slot
  function automatic logic [IDX_W-1:0] ssr_flat_index(input logic [CH_W-1:0] chan,
                                                      input logic [SLOT_W-1:0] slot);
    logic [IDX_W-1:0] ch_base;
    ch_base = (chan != '0) ? IDX_PER_CH : '0;
    if (slot == SLOT_OPER) begin
      return IDX_OPER;
    end else if (slot == SLOT_QUES) begin
      return IDX_QUES;
    end else begin
      return IDX_SUB_BASE + ch_base + IDX_W'(slot - SLOT_ACP);
    end
  endfunction : ssr_flat_index

endpackage : ssr_pkg

// ---- hw/ssr_status_bank.sv ----
// Status reporting register bank: groups, sub-registers, error queue, preset
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Preset loads every rising-edge filter with all ones.
// - Preset clears every falling-edge filter to zero.
// - Preset clears operation and questionable enable parts only.
// - Queue read returns newest error entry and removes it at once.
// - Reading an empty queue returns error number zero, meaning no error.
// - Error codes are signed; positive device, negative language errors.
// - Condition read returns current contents and changes nothing.
// - Event read returns contents and clears that event part.
// - Enabled event bit becoming true raises the register's summary bit.
// - Falling-filter bit set: condition 1-to-0 sets the event bit.
// - Rising-filter bit set: condition 0-to-1 sets the event bit.
// - Sub-registers per channel; unnamed access uses the active channel.
// - Five parts for both groups and every listed sub-register.
// - Limit and limit-margin sub-registers have one set per window.
module ssr_status_bank
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ssr_pkg::ADDR_W-1:0] addr,
  input wire logic [ssr_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ssr_pkg::DATA_W-1:0] rd_data,
  input wire logic [ssr_pkg::NUM_REGS*ssr_pkg::DATA_W-1:0] cond_in,
  input wire logic err_push,
  input wire logic signed [ssr_pkg::DATA_W-1:0] err_code,
  output logic [ssr_pkg::NUM_REGS-1:0] summary_out,
  output logic irq
);

  import ssr_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][DATA_W-1:0] cond_prev;
    logic [NUM_REGS-1:0][DATA_W-1:0] event_bits;
    logic [NUM_REGS-1:0][DATA_W-1:0] enable;
    logic [NUM_REGS-1:0][DATA_W-1:0] ptr;
    logic [NUM_REGS-1:0][DATA_W-1:0] ntr;
    logic [NUM_REGS-1:0] summary;
    logic [CH_W-1:0] active_ch;
    logic [QCNT_W-1:0] q_count;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [DATA_W-1:0] rd_word;
    logic rd_from_queue;
  } ssr_state_t;

  ssr_state_t q;
  ssr_state_t d;

  logic [NUM_REGS-1:0][DATA_W-1:0] cond_now;
  logic [NUM_REGS-1:0][DATA_W-1:0] edge_v;
  logic [CH_W-1:0] req_chan;
  logic [SLOT_W-1:0] req_slot;
  logic [PART_W-1:0] req_part;
  logic [IDX_W-1:0] req_idx;
  logic slot_is_reg;
  logic slot_is_ctrl;
  logic q_pop;
  logic q_full;
  logic mem_wr_en;
  logic [QUEUE_AW-1:0] mem_wr_addr;
  logic [QUEUE_AW-1:0] mem_rd_addr;
  logic signed [DATA_W-1:0] mem_rd_data;
  logic [IRQ_W-1:0] irq_events;

  assign cond_now = cond_in;

  // Address decode; a missing channel name falls back to the active channel
  assign req_slot = addr[SLOT_LSB +: SLOT_W];
  assign req_part = addr[PART_LSB +: PART_W];
  assign req_chan = addr[NAMED_BIT] ? addr[CHAN_BIT] : q.active_ch;
  // Window-indexed limit slots map to their own flat entries
  assign req_idx = ssr_flat_index(req_chan, req_slot);
  assign slot_is_reg = (req_slot <= SLOT_TIME);
  assign slot_is_ctrl = (req_slot == SLOT_CTRL);

  // Queue bookkeeping: a stack, since reads take the newest entry
  assign q_full = (q.q_count == QCNT_FULL);
  assign q_pop = rd_en && slot_is_ctrl && (req_part == CTRL_QUEUE) && (q.q_count != QCNT_EMPTY);
  assign mem_rd_addr = QUEUE_AW'(q.q_count - QCNT_ONE);

  always_comb begin
    mem_wr_en = 1'b0;
    mem_wr_addr = QUEUE_AW'(q.q_count);
    if (err_push && q_pop) begin
      // Popped slot is reused; the read port still returns the old word
      mem_wr_en = 1'b1;
      mem_wr_addr = QUEUE_AW'(q.q_count - QCNT_ONE);
    end else if (err_push && !q_full) begin
      mem_wr_en = 1'b1;
    end
  end

  ssr_err_mem u_err_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(err_code),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  always_comb begin
    d = q;
    irq_events = '0;

    // Edge detection against last cycle's condition, per enabled filter
    for (int i = 0; i < NUM_REGS; i++) begin
      edge_v[i] = (~q.cond_prev[i] & cond_now[i] & q.ptr[i])
                | (q.cond_prev[i] & ~cond_now[i] & q.ntr[i]);
      d.cond_prev[i] = cond_now[i];
      d.event_bits[i] = q.event_bits[i] | edge_v[i];
      d.summary[i] = |(q.event_bits[i] & q.enable[i]);
    end

    // Event read clears, but an edge seen in the same cycle survives
    if (rd_en && slot_is_reg && (req_part == PART_EVENT)) begin
      d.event_bits[req_idx] = edge_v[req_idx];
    end

    // Writes; data port is 16 bits so every value is within 0 to 65535
    if (wr_en && slot_is_reg) begin
      case (req_part)
        PART_ENABLE: d.enable[req_idx] = wr_data;
        PART_PTR: d.ptr[req_idx] = wr_data;
        PART_NTR: d.ntr[req_idx] = wr_data;
        default: ;
      endcase
    end else if (wr_en && slot_is_ctrl) begin
      case (req_part)
        CTRL_PRESET: begin
          for (int i = 0; i < NUM_REGS; i++) begin
            d.ptr[i] = PTR_PRESET;
            d.ntr[i] = NTR_PRESET;
          end
          // Sub-register enables are left as software set them
          d.enable[IDX_OPER] = ENA_PRESET;
          d.enable[IDX_QUES] = ENA_PRESET;
        end
        CTRL_ACTIVE: d.active_ch = wr_data[CH_W-1:0];
        CTRL_IRQ_EN: d.irq_enable = wr_data[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Queue depth; a push into a full queue is dropped and flagged, unless a pop in the same cycle frees its slot
    if (err_push && q_pop) begin
      d.q_count = q.q_count;
    end else if (err_push && !q_full) begin
      d.q_count = q.q_count + QCNT_ONE;
    end else if (err_push) begin
      irq_events[IRQ_OVF] = 1'b1;
    end else if (q_pop) begin
      d.q_count = q.q_count - QCNT_ONE;
    end

    // Summary rises of the two groups are reported as interrupts
    irq_events[IRQ_OPER] = d.summary[IDX_OPER] && !q.summary[IDX_OPER];
    irq_events[IRQ_QUES] = d.summary[IDX_QUES] && !q.summary[IDX_QUES];
    if (wr_en && slot_is_ctrl && (req_part == CTRL_IRQ_CLR)) begin
      d.irq_status = q.irq_status & ~wr_data[IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    d.irq_status = d.irq_status | irq_events;

    // Read data for the next cycle only
    d.rd_word = '0;
    d.rd_from_queue = 1'b0;
    if (rd_en && slot_is_reg) begin
      case (req_part)
        PART_COND: d.rd_word = cond_now[req_idx];
        PART_EVENT: d.rd_word = q.event_bits[req_idx];
        PART_ENABLE: d.rd_word = q.enable[req_idx];
        PART_PTR: d.rd_word = q.ptr[req_idx];
        PART_NTR: d.rd_word = q.ntr[req_idx];
        default: d.rd_word = '0;
      endcase
    end else if (rd_en && slot_is_ctrl) begin
      case (req_part)
        CTRL_QUEUE: begin
          if (q.q_count == QCNT_EMPTY) begin
            d.rd_word = NO_ERROR;
          end else begin
            d.rd_from_queue = 1'b1;
          end
        end
        CTRL_ACTIVE: d.rd_word = DATA_W'(q.active_ch);
        CTRL_IRQ_STAT: d.rd_word = DATA_W'(q.irq_status);
        CTRL_IRQ_EN: d.rd_word = DATA_W'(q.irq_enable);
        default: d.rd_word = '0;
      endcase
    end

    // Reset loads the preset filter values, clears all enables and zeroes all other state
    if (reset) begin
      d = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
        d.ptr[i] = PTR_PRESET;
        d.ntr[i] = NTR_PRESET;
        d.enable[i] = ENA_PRESET;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    q <= d;
  end

  // Queue word comes straight from the memory's read register
  assign rd_data = q.rd_from_queue ? mem_rd_data : q.rd_word;
  assign summary_out = q.summary;
  assign irq = |(q.irq_status & q.irq_enable);

endmodule : ssr_status_bank
`default_nettype wire

// ---- tb/ssr_host.sv ----
// Remote controller model on the register port
`timescale 1ns/1ns
`default_nettype none
module ssr_host
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  output logic [ssr_pkg::ADDR_W-1:0] addr,
  output logic [ssr_pkg::DATA_W-1:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [ssr_pkg::DATA_W-1:0] rd_data
);
  initial begin
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // Only 16-bit words can be sent, so no value out of range reaches the bank
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    // Released lines must not keep looking valid
    addr <= ~a;
    wr_data <= ~d;
    @(posedge ref_clk);
  endtask : write_reg
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge ref_clk);
    d = rd_data;
  endtask : read_reg
endmodule : ssr_host
`default_nettype wire

// ---- tb/ssr_status_bank_tb.sv ----
// Self-checking testbench for the status register bank
`timescale 1ns/1ns
`default_nettype none
module ssr_status_bank_tb;
  import ssr_pkg::*;
  logic ref_clk, reset, wr_en, rd_en, err_push, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [NUM_REGS*DATA_W-1:0] cond_in;
  logic signed [DATA_W-1:0] err_code;
  logic [NUM_REGS-1:0] summary_out;
  int mismatches, compares;
  ssr_status_bank dut_u (.ref_clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .cond_in, .err_push,
    .err_code, .summary_out, .irq);
  ssr_host host_u (.ref_clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
  function automatic logic [ADDR_W-1:0] ad(input logic [1:0] nc, input logic [SLOT_W-1:0] s,
                                           input logic [PART_W-1:0] p);
    return {nc, s, p};
  endfunction : ad
  function automatic logic [ADDR_W-1:0] o(input logic [PART_W-1:0] p);
    return {2'h0, SLOT_OPER, p};
  endfunction : o
  function automatic logic [ADDR_W-1:0] c(input logic [PART_W-1:0] p);
    return {2'h0, SLOT_CTRL, p};
  endfunction : c
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    host_u.read_reg(a, d);
    check(d, exp);
  endtask : rc
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host_u.write_reg(a, d);
  endtask : wr
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic t_preset();
    wr(o(PART_PTR), 16'h0000);
    wr(o(PART_NTR), 16'hFFFF);
    wr(o(PART_ENABLE), 16'h8001);
    rc(o(PART_ENABLE), 16'h8001);
    wr(ad(2'h3, SLOT_TIME, PART_PTR), 16'h0000);
    wr(ad(2'h3, SLOT_TIME, PART_ENABLE), 16'h00F0);
    wr(c(CTRL_PRESET), 16'h0000);
    rc(o(PART_PTR), 16'hFFFF);
    rc(o(PART_NTR), 16'h0000);
    rc(o(PART_ENABLE), 16'h0000);
    rc(ad(2'h3, SLOT_TIME, PART_PTR), 16'hFFFF);
    rc(ad(2'h3, SLOT_TIME, PART_ENABLE), 16'h00F0);
  endtask : t_preset
  task automatic t_edges();
    wr(o(PART_NTR), 16'h0001);
    wr(o(PART_PTR), 16'hFFFD);
    cond_in[15:0] <= 16'h0003;
    repeat (2) @(posedge ref_clk);
    // Bit 1 rose with its rising filter clear, so only bit 0 is recorded
    rc(o(PART_EVENT), 16'h0001);
    rc(o(PART_EVENT), 16'h0000);
    rc(o(PART_COND), 16'h0003);
    rc(o(PART_COND), 16'h0003);
    cond_in[15:0] <= 16'h0002;
    repeat (2) @(posedge ref_clk);
    rc(o(PART_EVENT), 16'h0001);
  endtask : t_edges
  task automatic t_summary();
    wr(c(CTRL_IRQ_EN), 16'h0002);
    wr(o(PART_ENABLE), 16'h0001);
    cond_in[15:0] <= 16'h0003;
    repeat (4) @(posedge ref_clk);
    check(16'(summary_out[0]), 16'h0001);
    check(16'(irq), 16'h0001);
    rc(c(CTRL_IRQ_STAT), 16'h0002);
    wr(c(CTRL_IRQ_EN), 16'h0000);
    check(16'(irq), 16'h0000);
    wr(c(CTRL_IRQ_CLR), 16'h0002);
    wr(c(CTRL_IRQ_EN), 16'h0002);
    check(16'(irq), 16'h0000);
    rc(o(PART_EVENT), 16'h0001);
    @(posedge ref_clk);
    check(16'(summary_out[0]), 16'h0000);
  endtask : t_summary
  task automatic t_queue();
    rc(c(CTRL_QUEUE), 16'h0000);
    err_push <= 1'b1;
    err_code <= 16'hFFFB;
    @(posedge ref_clk);
    err_code <= 16'h0007;
    @(posedge ref_clk);
    err_push <= 1'b0;
    rc(c(CTRL_QUEUE), 16'h0007);
    rc(c(CTRL_QUEUE), 16'hFFFB);
    rc(c(CTRL_QUEUE), 16'h0000);
    // One push more than the queue holds: the last is dropped and flagged
    for (int n = 1; n <= QUEUE_DEPTH + 1; n++) begin
      err_push <= 1'b1;
      err_code <= DATA_W'(n);
      @(posedge ref_clk);
    end
    err_push <= 1'b0;
    @(posedge ref_clk);
    rc(c(CTRL_IRQ_STAT), 16'h0001);
    rc(c(CTRL_QUEUE), 16'h0010);
  endtask : t_queue
  task automatic t_channel();
    cond_in[15*DATA_W +: DATA_W] <= 16'h1234;
    wr(c(CTRL_ACTIVE), 16'h0001);
    wr(ad(2'h0, SLOT_ACP, PART_ENABLE), 16'h00AA);
    rc(ad(2'h3, SLOT_ACP, PART_ENABLE), 16'h00AA);
    // Rising bits of 1234h meet enable 00AAh in bit 5
    check(16'(summary_out[15]), 16'h0001);
    rc(ad(2'h2, SLOT_ACP, PART_ENABLE), 16'h0000);
    rc(ad(2'h0, SLOT_ACP, PART_COND), 16'h1234);
    wr(ad(2'h2, SLOT_LIMIT_W1, PART_ENABLE), 16'h0055);
    rc(ad(2'h2, SLOT_LIMIT_W0, PART_ENABLE), 16'h0000);
    rc(ad(2'h2, SLOT_LIMIT_W1, PART_ENABLE), 16'h0055);
    for (int s = 2; s < 15; s++) begin
      wr(ad(2'h3, SLOT_W'(s), PART_NTR), DATA_W'(s));
      rc(ad(2'h3, SLOT_W'(s), PART_NTR), DATA_W'(s));
    end
    wr(o(3'h5), 16'hFFFF);
    rc(o(3'h5), 16'h0000);
  endtask : t_channel
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // The run needs under 2000 cycles; this margin only catches a hang
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    reset = 1'b1;
    cond_in = '0;
    err_push = 1'b0;
    err_code = '0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_preset();
    t_edges();
    t_summary();
    t_queue();
    t_channel();
    conclude();
  end
endmodule : ssr_status_bank_tb
`default_nettype wire

// ---- tb/ssr_status_monitor.sv ----
// Port assertions for the status register bank
`timescale 1ns/1ns
`default_nettype none
module ssr_status_monitor
  import ssr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ssr_pkg::ADDR_W-1:0] addr,
  input wire logic [ssr_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ssr_pkg::DATA_W-1:0] rd_data,
  input wire logic [ssr_pkg::NUM_REGS*ssr_pkg::DATA_W-1:0] cond_in,
  input wire logic err_push,
  input wire logic signed [ssr_pkg::DATA_W-1:0] err_code,
  input wire logic [ssr_pkg::NUM_REGS-1:0] summary_out,
  input wire logic irq
);
  localparam logic [5:0] OP = {2'h0, SLOT_OPER};
  localparam logic [5:0] CT = {2'h0, SLOT_CTRL};
  // Any later write may change the preset values, so the flag drops on it
  logic preset_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      preset_q <= 1'b0;
    end else if (wr_en) begin
      preset_q <= addr == {CT, CTRL_PRESET};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_cond_read_pure: assert property (
    rd_en && addr == {OP, PART_COND} |=> rd_data == $past(cond_in[15:0])) else $error("condition read");
  a_preset_rise: assert property (
    preset_q && rd_en && addr == {OP, PART_PTR} |=> rd_data == PTR_PRESET) else $error("rise filter");
  a_preset_fall: assert property (
    preset_q && rd_en && addr == {OP, PART_NTR} |=> rd_data == NTR_PRESET) else $error("fall filter");
  a_preset_enable: assert property (
    preset_q && rd_en && addr == {OP, PART_ENABLE} |=> rd_data == ENA_PRESET) else $error("enable");
  a_preset_quiet: assert property (
    preset_q && $past(preset_q) |-> summary_out[1:0] == 2'h0) else $error("summary");
  a_event_clears: assert property (
    (rd_en && addr == {OP, PART_EVENT} && $stable(cond_in[15:0])) ##1 $stable(cond_in[15:0])
    ##1 (rd_en && addr == {OP, PART_EVENT} && $stable(cond_in[15:0])) |=> rd_data == 16'h0000)
    else $error("event kept");
  a_enable_back: assert property (
    (wr_en && addr == {OP, PART_ENABLE}) ##1 !wr_en ##1 (rd_en && addr == {OP, PART_ENABLE})
    |=> rd_data == $past(wr_data, 3)) else $error("enable readback");
  a_queue_newest: assert property (
    err_push ##1 (rd_en && addr == {CT, CTRL_QUEUE} && !err_push) |=> rd_data == $past(err_code, 2))
    else $error("queue entry");
  c_summary: cover property ($rose(summary_out[0]));
  c_pop: cover property (err_push ##1 rd_en);
  c_irq: cover property ($rose(irq));
endmodule : ssr_status_monitor
bind ssr_status_bank ssr_status_monitor mon_u (.ref_clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
  .cond_in, .err_push, .err_code, .summary_out, .irq);
`default_nettype wire
